// *** logic/etrt_pkg.sv ***
package etrt_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int PSC_W = 4;
    localparam int PRESC_W = 15;
    localparam int WORD_SHIFT = 2;

    ////////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_COUNT = 8'h01;
    localparam logic [7:0] IDX_INT_ENABLE = 8'h0b;
    localparam logic [7:0] IDX_INT_FLAGS = 8'h0c;
    localparam logic [7:0] IDX_RELOAD = 8'h10;
    localparam logic [7:0] IDX_CONTROL = 8'h11;
    localparam logic [7:0] IDX_MISC = 8'h16;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int BIT_OVERFLOW = 4;
    localparam int BIT_HALT = 3;
    localparam int BIT_EDGE_SEL = 5;
    localparam int BIT_CLK_SEL = 4;
    localparam int PSC_LSB = 0;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and counting constants
    localparam logic [REG_W-1:0] RST_REG = 8'h00;
    localparam logic [REG_W-1:0] COUNT_MAX = 8'hff;
    localparam logic [REG_W-1:0] COUNT_STEP = 8'h01;
    localparam logic [PRESC_W-1:0] PRESC_ZERO = 15'h0000;
    localparam logic [PRESC_W-1:0] PRESC_STEP = 15'h0001;
    localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 12'h000;

    ////////////////////////////////////////////////////////////////////////////
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum {
        ETRT_SEL_NONE,
        ETRT_SEL_COUNT,
        ETRT_SEL_INT_ENABLE,
        ETRT_SEL_INT_FLAGS,
        ETRT_SEL_RELOAD,
        ETRT_SEL_CONTROL,
        ETRT_SEL_MISC
    } etrt_reg_sel_type;

    function automatic logic [ADDR_W-1:0] etrt_byte_addr(input logic [7:0] idx);
        etrt_byte_addr = ADDR_W'(idx) << WORD_SHIFT;
    endfunction

    function automatic etrt_reg_sel_type etrt_decode(input logic [ADDR_W-1:0] addr);
        if (addr == etrt_byte_addr(IDX_COUNT)) begin
            etrt_decode = ETRT_SEL_COUNT;
        end else if (addr == etrt_byte_addr(IDX_INT_ENABLE)) begin
            etrt_decode = ETRT_SEL_INT_ENABLE;
        end else if (addr == etrt_byte_addr(IDX_INT_FLAGS)) begin
            etrt_decode = ETRT_SEL_INT_FLAGS;
        end else if (addr == etrt_byte_addr(IDX_RELOAD)) begin
            etrt_decode = ETRT_SEL_RELOAD;
        end else if (addr == etrt_byte_addr(IDX_CONTROL)) begin
            etrt_decode = ETRT_SEL_CONTROL;
        end else if (addr == etrt_byte_addr(IDX_MISC)) begin
            etrt_decode = ETRT_SEL_MISC;
        end else begin
            etrt_decode = ETRT_SEL_NONE;
        end
    endfunction

endpackage

// *** logic/etrt_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module etrt_sync (
    // clock and control
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // level in and out
    input wire logic async_in,
    output logic sync_out
);
    import etrt_pkg::*;

    logic stage_one;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage_one <= 1'b0;
            sync_out <= 1'b0;
        end else if (ce) begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end

endmodule
`default_nettype wire

// *** logic/etrt_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none
module etrt_prescaler (
    // clock and control
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // source and setup
    input wire logic src_tick,
    input wire logic clear,
    input wire logic [etrt_pkg::PSC_W-1:0] prescale_select,
    // divided output
    output logic prescaled_tick_pulse
);
    import etrt_pkg::*;

    logic [PRESC_W-1:0] presc_count;
    logic [PRESC_W-1:0] presc_mask;

    // divide by two to the n
    assign presc_mask = ~({PRESC_W{1'b1}} << prescale_select);
    assign prescaled_tick_pulse = src_tick && ((presc_count & presc_mask) == presc_mask);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc_count <= PRESC_ZERO;
        end else if (ce) begin
            // clear on setup or count write
            if (clear) begin
                presc_count <= PRESC_ZERO;
            end else if (prescaled_tick_pulse) begin
                presc_count <= PRESC_ZERO;
            end else if (src_tick) begin
                presc_count <= presc_count + PRESC_STEP;
            end
        end
    end

endmodule
`default_nettype wire

// *** logic/etrt_timer.sv ***
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module etrt_timer (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // write address channel
    input wire logic awvalid,
    output logic awready,
    input wire logic [etrt_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // write data channel
    input wire logic wvalid,
    output logic wready,
    input wire logic [etrt_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    // write response channel
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // read address channel
    input wire logic arvalid,
    output logic arready,
    input wire logic [etrt_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // read data channel
    output logic rvalid,
    input wire logic rready,
    output logic [etrt_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    // pin and cpu request
    input wire logic external_count_input,
    output logic overflow_interrupt_request
);
    import etrt_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [REG_W-1:0] timer_zero_count;
    logic [REG_W-1:0] reload_value;
    logic [BIT_EDGE_SEL:0] timer_control_reg;
    logic overflow_interrupt_enable;
    logic overflow_pending_flag;
    logic counting_halt;

    // bus holding state
    logic aw_full;
    logic w_full;
    logic [ADDR_W-1:0] aw_addr_hold;
    logic [REG_W-1:0] w_data_hold;
    logic w_lane_hold;

    // timing
    logic instr_phase;
    logic pin_sync;
    logic pin_sampled;
    logic src_tick;
    logic prescaled_tick_pulse;
    logic direct_write_pulse;
    logic control_write_pulse;
    logic do_write;
    logic rollover;
    etrt_reg_sel_type wr_sel;

    ////////////////////////////////////////////////////////////////////////////
    // write decode
    assign do_write = aw_full && w_full && !bvalid;
    assign wr_sel = etrt_decode(aw_addr_hold);
    assign direct_write_pulse = do_write && w_lane_hold && (wr_sel == ETRT_SEL_COUNT);
    assign control_write_pulse = do_write && w_lane_hold && (wr_sel == ETRT_SEL_CONTROL);

    ////////////////////////////////////////////////////////////////////////////
    // write channels; address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            aw_full <= 1'b0;
            aw_addr_hold <= ADDR_ZERO;
        end else if (ce) begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_full <= 1'b1;
                aw_addr_hold <= awaddr;
            end else if (do_write) begin
                aw_full <= 1'b0;
            end else if (!aw_full && !bvalid) begin
                awready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready <= 1'b0;
            w_full <= 1'b0;
            w_data_hold <= RST_REG;
            w_lane_hold <= 1'b0;
        end else if (ce) begin
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_full <= 1'b1;
                w_data_hold <= wdata[REG_W-1:0];
                w_lane_hold <= wstrb[0];
            end else if (do_write) begin
                w_full <= 1'b0;
            end else if (!w_full && !bvalid) begin
                wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                bvalid <= 1'b1;
                bresp <= (wr_sel == ETRT_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channel; reads have no side effects
    function automatic logic [DATA_W-1:0] read_mux(input etrt_reg_sel_type sel);
        logic [REG_W-1:0] value;
        value = RST_REG;
        case (sel)
            ETRT_SEL_COUNT: value = timer_zero_count;
            ETRT_SEL_INT_ENABLE: value[BIT_OVERFLOW] = overflow_interrupt_enable;
            ETRT_SEL_INT_FLAGS: value[BIT_OVERFLOW] = overflow_pending_flag;
            ETRT_SEL_RELOAD: value = reload_value;
            ETRT_SEL_CONTROL: value = REG_W'(timer_control_reg);
            ETRT_SEL_MISC: value[BIT_HALT] = counting_halt;
            default: value = RST_REG;
        endcase
        read_mux = DATA_W'(value);
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= RDATA_ZERO;
            rresp <= RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= read_mux(etrt_decode(araddr));
                rresp <= (etrt_decode(araddr) == ETRT_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end else if (!rvalid) begin
                arready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reload_value <= RST_REG;
            timer_control_reg <= RST_REG[BIT_EDGE_SEL:0];
            overflow_interrupt_enable <= 1'b0;
            counting_halt <= 1'b0;
        end else if (ce && do_write && w_lane_hold) begin
            if (wr_sel == ETRT_SEL_RELOAD) begin
                reload_value <= w_data_hold;
            end else if (wr_sel == ETRT_SEL_CONTROL) begin
                timer_control_reg <= w_data_hold[BIT_EDGE_SEL:0];
            end else if (wr_sel == ETRT_SEL_INT_ENABLE) begin
                overflow_interrupt_enable <= w_data_hold[BIT_OVERFLOW];
            end else if (wr_sel == ETRT_SEL_MISC) begin
                counting_halt <= w_data_hold[BIT_HALT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // instruction cycle and pin edge detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_phase <= 1'b0;
        end else if (ce) begin
            instr_phase <= ~instr_phase;
        end
    end

    etrt_sync u_pin_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .async_in(external_count_input),
        .sync_out(pin_sync)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_sampled <= 1'b0;
        end else if (ce && instr_phase) begin
            pin_sampled <= pin_sync;
        end
    end

    always_comb begin
        src_tick = instr_phase;
        if (timer_control_reg[BIT_CLK_SEL]) begin
            if (timer_control_reg[BIT_EDGE_SEL]) begin
                src_tick = instr_phase && pin_sampled && !pin_sync;
            end else begin
                src_tick = instr_phase && !pin_sampled && pin_sync;
            end
        end
    end

    etrt_prescaler u_prescaler (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .src_tick(src_tick),
        .clear(control_write_pulse || direct_write_pulse),
        .prescale_select(timer_control_reg[PSC_LSB +: PSC_W]),
        .prescaled_tick_pulse(prescaled_tick_pulse)
    );

    ////////////////////////////////////////////////////////////////////////////
    // counter
    // halted ticks never roll over; software write still loads
    assign rollover = prescaled_tick_pulse && !counting_halt && !direct_write_pulse
        && (timer_zero_count == COUNT_MAX);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_zero_count <= RST_REG;
        end else if (ce) begin
            // software load wins over a tick
            if (direct_write_pulse) begin
                timer_zero_count <= w_data_hold;
            end else if (rollover) begin
                timer_zero_count <= reload_value;
            end else if (prescaled_tick_pulse && !counting_halt) begin
                // one step per tick unless halted
                timer_zero_count <= timer_zero_count + COUNT_STEP;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // overflow flag and request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overflow_pending_flag <= 1'b0;
        end else if (ce) begin
            // set wins over a clear in the same cycle
            if (rollover) begin
                overflow_pending_flag <= 1'b1;
            end else if (do_write && w_lane_hold && (wr_sel == ETRT_SEL_INT_FLAGS)
                && !w_data_hold[BIT_OVERFLOW]) begin
                overflow_pending_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overflow_interrupt_request <= 1'b0;
        end else if (ce) begin
            overflow_interrupt_request <= overflow_pending_flag && overflow_interrupt_enable;
        end
    end

endmodule
`default_nettype wire

// *** sim/etrt_timer_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module etrt_timer_checker
    import etrt_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write side
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    // read side
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [1:0] rresp,
    // cpu request
    input wire logic overflow_interrupt_request
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic mapped;
    assign mapped = araddr inside {12'h004, 12'h02c, 12'h030, 12'h040, 12'h044, 12'h058};
    ////////////////////////////////////////////////////////////////////////////
    sequence s_wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_rd_taken;
        arvalid && arready;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_read_answer: assert property (s_rd_taken |=> rvalid)
        else $error("read not answered next cycle");
    a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped before rready");
    a_read_width: assert property (rvalid |-> rdata[31:8] == 24'h0 && !arready)
        else $error("read word wider than register");
    a_write_answer: assert property (s_wr_taken |-> ##[2:3] bvalid)
        else $error("write response late");
    a_write_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    a_ready_return: assert property (bvalid && bready |-> ##[1:2] (awready && wready))
        else $error("write channels not reopened");
    a_unmapped_err: assert property (s_rd_taken ##0 !mapped |=> rresp == RESP_SLVERR)
        else $error("unmapped read not refused");
    // enable cleared: request must fall within the register delay
    a_irq_gated: assert property (s_wr_taken ##0 (awaddr == 12'h02c && wstrb[0] && !wdata[4])
        |-> ##[1:4] !overflow_interrupt_request)
        else $error("request stays with enable off");
endmodule
`default_nettype wire

// *** sim/etrt_pin_src.sv ***
`timescale 1ns/1ps
`default_nettype none
module etrt_pin_src (
    // clock
    input wire logic aclk,
    // count pin
    output logic pin
);
    initial pin = 1'b0;
    // level hold time
    // each level lasts hold cycles, at least two instruction cycles; idle pin stands still
    task automatic send(input int edges, input int hold);
        for (int i = 0; i < edges; i++) begin
            repeat (hold) @(posedge aclk);
            pin <= ~pin;
        end
        repeat (8) @(posedge aclk);
    endtask
endmodule
`default_nettype wire

// *** sim/eight_bit_reload_timer_counter_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module eight_bit_reload_timer_counter_test;
    import etrt_pkg::*;
    localparam logic [11:0] A_CNT = 12'h004;
    localparam logic [11:0] A_IE = 12'h02c;
    localparam logic [11:0] A_IF = 12'h030;
    localparam logic [11:0] A_RLD = 12'h040;
    localparam logic [11:0] A_CTL = 12'h044;
    localparam logic [11:0] A_MISC = 12'h058;
    logic [11:0] regs [6] = '{A_CNT, A_IE, A_IF, A_RLD, A_CTL, A_MISC};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic awready, wready, bvalid, arready, rvalid, irq, pin;
    logic [1:0] bresp, rresp, last_resp, rd_resp;
    logic [31:0] rdata, rd_data;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    int t0, t1;
    always #2.5 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;
    // protection and strobes tied; ce dropped once to prove the freeze
    etrt_timer dut_u (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .external_count_input(pin), .overflow_interrupt_request(irq)
    );
    etrt_pin_src src_u (.aclk(aclk), .pin(pin));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= {24'h00_0000, d};
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        last_resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd_data = rdata;
        rd_resp = rresp;
        rready <= 1'b0;
    endtask
    // bounded wait for a high request level; returns the cycle stamp
    task automatic wait_irq(output int t);
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (irq !== 1'b1 && n < 10000);
        if (n >= 10000) err_total++;
        t = cyc;
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge aclk);
        err_total++;
        stop_test();
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (regs[i]) begin
            rd(regs[i]);
            chk("reset value", rd_data, 32'h0);
        end
        rd(12'h008);
        chk("unmapped rresp", rd_resp, RESP_SLVERR);
        wr(12'h008, 8'hff);
        chk("unmapped bresp", last_resp, RESP_SLVERR);
        // halted: value holds, registers still reachable
        wr(A_MISC, 8'h08);
        wr(A_CNT, 8'h5a);
        wr(A_RLD, 8'hf0);
        repeat (60) @(posedge aclk);
        rd(A_CNT);
        chk("halted count", rd_data, 32'h5a);
        rd(A_IF);
        chk("halted flag", rd_data, 32'h0);
        // rollover spacing for prescale codes 0..7; higher codes run too long here
        wr(A_IE, 8'h10);
        wr(A_MISC, 8'h00);
        for (int n = 0; n < 8; n++) begin
            wr(A_CTL, 8'(n));
            wr(A_IF, 8'h00);
            wait_irq(t0);
            wr(A_IF, 8'h00);
            wait_irq(t1);
            chk("interval", 32'(t1 - t0), 32'(2 * (1 << n) * (256 - 8'hf0)));
        end
        // enable off: flag still set, request gated
        wr(A_CTL, 8'h00);
        wr(A_IE, 8'h00);
        wr(A_IF, 8'h00);
        repeat (100) @(posedge aclk);
        chk("gated request", irq, 1'b0);
        rd(A_IF);
        chk("flag set", rd_data, 32'h10);
        wr(A_IE, 8'h10);
        repeat (3) @(posedge aclk);
        chk("enabled request", irq, 1'b1);
        wr(A_MISC, 8'h08);
        wr(A_IF, 8'h10);
        rd(A_IF);
        chk("flag kept", rd_data, 32'h10);
        wr(A_IF, 8'h00);
        rd(A_IF);
        chk("flag cleared", rd_data, 32'h0);
        // pin mode: low start, 5 edges give 3 rising
        wr(A_CTL, 8'h10);
        wr(A_CNT, 8'h00);
        wr(A_MISC, 8'h00);
        src_u.send(5, 4);
        wr(A_MISC, 8'h08);
        rd(A_CNT);
        chk("rising count", rd_data, 32'h3);
        // falling edges, slow source: from high, 4 edges give 2 falling
        wr(A_CTL, 8'h30);
        wr(A_CNT, 8'h00);
        wr(A_MISC, 8'h00);
        src_u.send(4, 6);
        wr(A_MISC, 8'h08);
        rd(A_CNT);
        chk("falling count", rd_data, 32'h2);
        // pin source divided by two: 4 rising edges
        wr(A_CTL, 8'h11);
        wr(A_CNT, 8'h00);
        wr(A_MISC, 8'h00);
        src_u.send(8, 4);
        wr(A_MISC, 8'h08);
        rd(A_CNT);
        chk("divided pin count", rd_data, 32'h2);
        // frozen clock enable: a pin rise while frozen must be lost
        wr(A_CTL, 8'h10);
        wr(A_RLD, 8'h33);
        wr(A_CNT, 8'hff);
        wr(A_MISC, 8'h00);
        repeat (2) @(posedge aclk);
        ce <= 1'b0;
        src_u.send(2, 4);
        ce <= 1'b1;
        rd(A_CNT);
        chk("frozen count", rd_data, 32'hff);
        // one rise from the maximum reloads and sets the flag
        src_u.send(2, 4);
        rd(A_CNT);
        chk("reloaded count", rd_data, 32'h33);
        rd(A_IF);
        chk("rollover flag", rd_data, 32'h10);
        // divide by two: a half-filled prescaler is cleared by either write
        wr(A_CTL, 8'h11);
        src_u.send(2, 4);
        wr(A_CNT, 8'h40);
        src_u.send(2, 4);
        rd(A_CNT);
        chk("count write clears", rd_data, 32'h40);
        wr(A_CTL, 8'h11);
        src_u.send(2, 4);
        rd(A_CNT);
        chk("control write clears", rd_data, 32'h40);
        stop_test();
    end
endmodule
bind etrt_timer etrt_timer_checker chk_u (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .overflow_interrupt_request(overflow_interrupt_request)
);
`default_nettype wire
